// ### rtl/uec_pkg.sv
// Package with register map, field layout and carrier types for the endpoint config block
package uec_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] UEC_IDX_TX_CTRL_HIGH = 10'h113;
    localparam logic [9:0] UEC_IDX_RX_MAXP1 = 10'h114;
    localparam logic [9:0] UEC_IDX_RX_MAXP2 = 10'h124;
    localparam logic [9:0] UEC_IDX_RX_MAXP3 = 10'h134;
    localparam logic [9:0] UEC_IDX_TX_MAXP = 10'h150;
    localparam logic [9:0] UEC_IDX_TX_STATUS = 10'h151;
    localparam int UEC_ADDR_W = 12;
    localparam int UEC_RX_EPS = 3;

    // Transmit control byte fields
    localparam int UEC_B_AUTO = 7;
    localparam int UEC_B_ISO = 6;
    localparam int UEC_B_DIR = 5;
    localparam int UEC_B_DMA_REQUEST_ENABLE = 4;
    localparam int UEC_B_FLIP = 3;
    localparam int UEC_B_DMA_REQUEST_VARIANT = 2;
    localparam logic [7:0] UEC_CTRL_WMASK = 8'hFC;
    localparam logic [7:0] UEC_CTRL_RST = 8'h00;

    // Receive max packet fields
    localparam int UEC_MAX_PAYLOAD_BYTES_LSB = 0;
    localparam int UEC_MAX_PAYLOAD_BYTES_W = 11;
    localparam int UEC_SPLIT_LSB = 11;
    localparam int UEC_SPLIT_W = 5;
    localparam logic [15:0] UEC_MAXP_RST = 16'h0000;

    // Transmit status fields
    localparam int UEC_S_READY = 0;
    localparam int UEC_S_TOGGLE = 1;
    localparam int UEC_S_SHARED = 2;

    // AXI response codes
    localparam logic [1:0] UEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] UEC_RESP_SLVERR = 2'h2;

    // Per receive endpoint settings
    typedef struct packed {
        logic [UEC_SPLIT_W-1:0] packet_split_factor;
        logic [UEC_MAX_PAYLOAD_BYTES_W-1:0] max_payload_bytes;
    } uec_rx_maxp_t;

    // Transmit endpoint settings seen by the datapath
    typedef struct packed {
        logic tx_packet_ready;
        logic iso_mode;
        logic dir_tx;
        logic dma_request_variant;
        logic data_toggle;
    } uec_tx_cfg_t;

    // Events from the transmit datapath
    typedef struct packed {
        logic [11:0] fifo_bytes;
        logic packet_sent;
        logic ack_rcvd;
        logic dma_space;
        logic shared_fifo;
    } uec_tx_evt_t;
endpackage

// ### rtl/uec_ctrl.sv
// Endpoint transmit control byte and receive max packet registers behind AXI4-Lite
`timescale 1ns/100ps
// Operation
// (RULE_01) With auto-ready on, a full max-size packet in FIFO sets packet-ready.
// (RULE_02) Software avoids auto-ready on high-bandwidth isochronous or interrupt endpoints.
// (RULE_03) Isochronous bit one selects isochronous, zero selects bulk or interrupt.
// (RULE_04) Direction bit one means transmit, zero means receive.
// (RULE_05) Direction bit only matters when the endpoint FIFO is shared.
// (RULE_06) DMA request enable gates the transmit DMA request.
// (RULE_07) Force-toggle flips data toggle and discards current packet regardless of ACK.
// (RULE_08) DMA variant bit one selects request mode 1, zero mode 0.
// (RULE_09) Software never clears the variant before or with clearing DMA enable.
// (RULE_10) Control bits one and zero are reserved, read zero, ignore writes.
// (RULE_11) Low eleven bits hold max payload bytes, up to 1024.
// (RULE_12) Upper five bits hold split multiplier minus one.
// (RULE_13) Software keeps payload times multiplier within the receive FIFO.
// (RULE_14) In DMA mode 1 software programs an even receive payload.
// (RULE_15) Receive max packet registers and control byte reset to zero.
// (RULE_16) Software sets packet-ready; hardware clears it once the packet is sent.
// (RULE_17) Automatic packet-ready has the same effect as a software write.
// (RULE_18) Three receive endpoints each own an identical max packet register.
module uec_ctrl
    import uec_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [UEC_ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [UEC_ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire uec_tx_evt_t tx_evt,
    output uec_tx_cfg_t tx_cfg,
    output logic tx_dma_req,
    output logic tx_flush,
    output uec_rx_maxp_t [UEC_RX_EPS-1:0] rx_maxp
);

    // Write and read channel holding registers
    logic aw_full_r;
    logic w_full_r;
    logic [UEC_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // Register state
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [10:0] tx_maxp_r;
    logic ready_r;
    logic ready_nxt;
    logic toggle_r;
    logic flush_r;
    logic [15:0] rx_maxp_r [UEC_RX_EPS];

    // Handshake terms
    wire aw_hs = s_axil_awvalid & s_axil_awready;
    wire w_hs = s_axil_wvalid & s_axil_wready;
    wire ar_hs = s_axil_arvalid & s_axil_arready;
    wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
    wire [9:0] wr_idx = aw_addr_r[UEC_ADDR_W-1:2];
    wire [9:0] rd_idx = s_axil_araddr[UEC_ADDR_W-1:2];

    // Write decode
    wire wr_ctrl = do_wr & (wr_idx == UEC_IDX_TX_CTRL_HIGH) & w_strb_r[0];
    wire wr_txmaxp = do_wr & (wr_idx == UEC_IDX_TX_MAXP);
    wire wr_stat = do_wr & (wr_idx == UEC_IDX_TX_STATUS) & w_strb_r[0];
    wire [2:0] wr_rx;
    wire [2:0] rd_rx;
    wire [9:0] rx_idx [UEC_RX_EPS];
    assign rx_idx[0] = UEC_IDX_RX_MAXP1;
    assign rx_idx[1] = UEC_IDX_RX_MAXP2;
    assign rx_idx[2] = UEC_IDX_RX_MAXP3;
    wire [2:0] wr_rx_any;
    // Unmapped index answers with an error response and changes nothing
    wire wr_hit = (wr_idx == UEC_IDX_TX_CTRL_HIGH) | (wr_idx == UEC_IDX_TX_MAXP)
        | (wr_idx == UEC_IDX_TX_STATUS) | (|wr_rx_any);

    // Control byte bit views
    wire auto_ready_enable = ctrl_r[UEC_B_AUTO];
    wire dma_request_enable = ctrl_r[UEC_B_DMA_REQUEST_ENABLE];
    wire dma_request_variant = ctrl_r[UEC_B_DMA_REQUEST_VARIANT];

    // Force flip takes effect on a write of one to its bit
    wire flip_req = wr_ctrl & w_data_r[UEC_B_FLIP]; // [RULE_07]

    // Auto ready when a full max-size packet sits in the FIFO
    wire auto_set = auto_ready_enable & ~ready_r & (tx_maxp_r != 11'h000)
        & (tx_evt.fifo_bytes >= {1'b0, tx_maxp_r}); // [RULE_01]
    wire sw_set = wr_stat & w_data_r[UEC_S_READY];
    wire ready_set = sw_set | auto_set; // [RULE_17]
    wire ready_clr = tx_evt.packet_sent | flip_req; // [RULE_16]

    // Set wins over clear
    always_comb begin
        ready_nxt = ready_r;
        if (ready_clr) begin
            ready_nxt = 1'b0;
        end
        if (ready_set) begin
            ready_nxt = 1'b1;
        end
    end

    // Control byte next value; reserved bits stay zero, flip bit self-clears
    always_comb begin
        ctrl_nxt = ctrl_r & ~(8'h01 << UEC_B_FLIP);
        if (wr_ctrl) begin
            ctrl_nxt = w_data_r[7:0] & UEC_CTRL_WMASK; // [RULE_10]
            ctrl_nxt[UEC_B_FLIP] = 1'b0;
        end
    end

    // Receive endpoint decode, one per endpoint
    genvar gi;
    generate
        for (gi = 0; gi < UEC_RX_EPS; gi++) begin : g_rx
            assign wr_rx_any[gi] = (wr_idx == rx_idx[gi]);
            assign wr_rx[gi] = do_wr & wr_rx_any[gi];
            assign rd_rx[gi] = (rd_idx == rx_idx[gi]);
            // Independent copy per endpoint
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    rx_maxp_r[gi] <= UEC_MAXP_RST; // [RULE_15]
                end else if (ce && wr_rx[gi]) begin
                    if (w_strb_r[0]) begin
                        rx_maxp_r[gi][7:0] <= w_data_r[7:0]; // [RULE_11]
                    end
                    if (w_strb_r[1]) begin
                        rx_maxp_r[gi][15:8] <= w_data_r[15:8]; // [RULE_12]
                    end
                end
            end
            assign rx_maxp[gi].max_payload_bytes =
                rx_maxp_r[gi][UEC_MAX_PAYLOAD_BYTES_LSB +: UEC_MAX_PAYLOAD_BYTES_W]; // [RULE_18]
            assign rx_maxp[gi].packet_split_factor =
                rx_maxp_r[gi][UEC_SPLIT_LSB +: UEC_SPLIT_W];
        end
    endgenerate

    // Control, max packet and ready state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= UEC_CTRL_RST; // [RULE_15]
            tx_maxp_r <= UEC_MAXP_RST[UEC_MAX_PAYLOAD_BYTES_W-1:0];
            ready_r <= 1'b0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            ready_r <= ready_nxt;
            if (wr_txmaxp && w_strb_r[0]) begin
                tx_maxp_r[7:0] <= w_data_r[7:0];
            end
            if (wr_txmaxp && w_strb_r[1]) begin
                tx_maxp_r[10:8] <= w_data_r[10:8];
            end
        end
    end

    // Data toggle flips on ACK or on forced flip; flush pulses on forced flip
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle_r <= 1'b0;
            flush_r <= 1'b0;
        end else if (ce) begin
            flush_r <= flip_req; // [RULE_07]
            if (flip_req || tx_evt.ack_rcvd) begin
                toggle_r <= ~toggle_r; // [RULE_07]
            end
        end
    end

    // Settings toward the datapath
    assign tx_cfg.tx_packet_ready = ready_r;
    assign tx_cfg.iso_mode = ctrl_r[UEC_B_ISO]; // [RULE_03]
    assign tx_cfg.dir_tx = tx_evt.shared_fifo ? ctrl_r[UEC_B_DIR] : 1'b1; // [RULE_04] [RULE_05]
    assign tx_cfg.dma_request_variant = dma_request_variant; // [RULE_08]
    assign tx_cfg.data_toggle = toggle_r;
    assign tx_flush = flush_r;

    // Mode 0 asks only while no packet is pending; mode 1 asks whenever space exists
    wire dma_mode_ok = dma_request_variant | ~ready_r; // [RULE_08]
    assign tx_dma_req = dma_request_enable & tx_evt.dma_space & dma_mode_ok; // [RULE_06]

    // Write address/data capture in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= UEC_RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axil_awaddr;
            end
            if (w_hs) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axil_wdata;
                w_strb_r <= s_axil_wstrb;
            end
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? UEC_RESP_OKAY : UEC_RESP_SLVERR;
            end else if (bvalid_r && s_axil_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axil_awready = ce & ~aw_full_r & ~bvalid_r;
    assign s_axil_wready = ce & ~w_full_r & ~bvalid_r;
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;

    // Read data selection
    wire rd_ctrl = (rd_idx == UEC_IDX_TX_CTRL_HIGH);
    wire rd_txmaxp = (rd_idx == UEC_IDX_TX_MAXP);
    wire rd_stat = (rd_idx == UEC_IDX_TX_STATUS);
    wire rd_hit = rd_ctrl | rd_txmaxp | rd_stat | (|rd_rx);
    wire [31:0] stat_word = {29'h0, tx_evt.shared_fifo, toggle_r, ready_r};
    wire [31:0] rd_mux =
        rd_ctrl ? {24'h0, ctrl_r} :
        rd_txmaxp ? {21'h0, tx_maxp_r} :
        rd_stat ? stat_word :
        rd_rx[0] ? {16'h0, rx_maxp_r[0]} :
        rd_rx[1] ? {16'h0, rx_maxp_r[1]} :
        rd_rx[2] ? {16'h0, rx_maxp_r[2]} : 32'h0000_0000;

    // Read channel: one read in flight, answer the cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= UEC_RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? UEC_RESP_OKAY : UEC_RESP_SLVERR;
            end else if (rvalid_r && s_axil_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axil_arready = ce & ~rvalid_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rdata = rdata_r;
    assign s_axil_rresp = rresp_r;

endmodule // uec_ctrl

// ### bench/uec_ctrl_properties.sv
// Port checks for the endpoint config block
`timescale 1ns/100ps
module uec_ctrl_chk
    import uec_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire uec_tx_evt_t tx_evt,
    input wire uec_tx_cfg_t tx_cfg,
    input wire logic tx_dma_req,
    input wire logic tx_flush,
    input wire uec_rx_maxp_t [UEC_RX_EPS-1:0] rx_maxp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Register state, strobes and handshakes
    reset_zero_a: assert property ($rose(aresetn) |-> rx_maxp == '0 && !tx_flush &&
        !tx_cfg.tx_packet_ready && !s_axil_bvalid) else $error("reset state");
    dma_gate_a: assert property (tx_dma_req |-> tx_evt.dma_space &&
        (tx_cfg.dma_request_variant || !tx_cfg.tx_packet_ready)) else $error("dma gate");
    dir_fixed_a: assert property (!tx_evt.shared_fifo |-> tx_cfg.dir_tx)
        else $error("direction");
    flush_pulse_a: assert property (tx_flush |=> !tx_flush)
        else $error("flush width");
    maxp_write_a: assert property ($changed(rx_maxp) |-> $rose(s_axil_bvalid))
        else $error("max packet");
    write_lat_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid &&
        s_axil_wready |=> !s_axil_bvalid ##1 s_axil_bvalid) else $error("write latency");
    bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=>
        s_axil_bvalid && $stable(s_axil_bresp)) else $error("write response");
    rdata_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata)) else $error("read data");
    flush_c: cover property (tx_flush);
    ready_c: cover property ($rose(tx_cfg.tx_packet_ready) && !s_axil_bvalid);
    dma_c: cover property (tx_dma_req);
endmodule // uec_ctrl_chk

bind uec_ctrl uec_ctrl_chk i_chk (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_rdata, .s_axil_rvalid, .s_axil_rready, .tx_evt, .tx_cfg, .tx_dma_req,
    .tx_flush, .rx_maxp);

// ### bench/uec_tx_partner.sv
// Transmit datapath model that drains packets marked ready
`timescale 1ns/100ps
module uec_tx_partner
    import uec_pkg::*;
(
    input wire logic aclk,
    input wire uec_tx_cfg_t tx_cfg,
    input wire logic [11:0] fill,
    input wire logic [3:0] lag,
    input wire logic shared,
    input wire logic space,
    output uec_tx_evt_t tx_evt
);
    logic [3:0] cnt_r = 4'h0;
    logic sent_r = 1'b0;
    // Levels from the FIFO side; send and acknowledge pulse together
    assign tx_evt = {fill, sent_r, sent_r, space, shared};
    // Sends a ready packet lag plus one cycles after ready rises; zero lag never sends
    always @(posedge aclk) begin
        cnt_r <= (tx_cfg.tx_packet_ready && !sent_r && cnt_r != lag) ? cnt_r + 4'h1 : 4'h0;
        sent_r <= tx_cfg.tx_packet_ready && !sent_r && lag != 4'h0 && cnt_r == lag;
    end
endmodule // uec_tx_partner

// ### bench/testbench.sv
// Self-checking bench for the endpoint config block
`timescale 1ns/100ps
module testbench;
    import uec_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, shared = 1'b0, space = 1'b0, tg = 1'b0;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, tx_dma_req, tx_flush;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [3:0] s_axil_wstrb = 4'hF, lag = 4'h0, s;
    logic [11:0] s_axil_awaddr = 12'h000, s_axil_araddr = 12'h000, fill = 12'h000;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, v, seed = 32'h2C73;
    logic [15:0] m [3] = '{16'h0, 16'h0, 16'h0};
    logic [7:0] seq [5] = '{8'hBF, 8'h54, 8'h44, 8'h20, 8'h00};
    logic [9:0] map [4] = '{UEC_IDX_TX_CTRL_HIGH, UEC_IDX_RX_MAXP1, UEC_IDX_RX_MAXP2,
        UEC_IDX_RX_MAXP3};
    int err_count = 0, check_count = 0, flips = 0, n;
    uec_tx_evt_t tx_evt;
    uec_tx_cfg_t tx_cfg;
    uec_rx_maxp_t [UEC_RX_EPS-1:0] rx_maxp;

    uec_ctrl i_dut (.aclk, .aresetn, .ce, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
        .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
        .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .tx_evt, .tx_cfg,
        .tx_dma_req, .tx_flush, .rx_maxp);
    uec_tx_partner i_far (.aclk, .tx_cfg, .fill, .lag, .shared, .space, .tx_evt);

    // Clock and flush pulse count
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (tx_flush === 1'b1) flips++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        if (n >= 40) begin
            err_count++;
            close_out();
        end
    endtask
    // Bus write with a randomly late response ready
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] st,
        input logic [1:0] r);
        @(posedge aclk);
        {s_axil_awaddr, s_axil_wdata, s_axil_wstrb} <= {a, 2'h0, d, st};
        {s_axil_awvalid, s_axil_wvalid} <= 2'h3;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axil_bvalid && s_axil_bready) break;
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            if (n >= seed[1:0]) s_axil_bready <= 1'b1;
        end
        tmo();
        s_axil_bready <= 1'b0;
        chk(s_axil_bresp, r);
    endtask
    // Bus read with a randomly late data ready
    task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axil_araddr <= {a, 2'h0};
        s_axil_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axil_rvalid && s_axil_rready) break;
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
            if (n >= seed[2:1]) s_axil_rready <= 1'b1;
        end
        tmo();
        s_axil_rready <= 1'b0;
        chk({s_axil_rresp, s_axil_rdata}, {r, d});
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(map[i], 32'h0, UEC_RESP_OKAY);
    endtask

    // Main sequence
    initial begin
        rst();
        // Receive max packet per endpoint and byte lane
        for (int i = 0; i < 12; i++) begin
            // Even payload below 128 bytes keeps payload times split inside the FIFO
            v = rnd() & 32'hF000_F87E;
            s = v[31:28];
            if (s[0]) m[i%3][7:0] = v[7:0];
            if (s[1]) m[i%3][15:8] = v[15:8];
            wr(map[i%3+1], v, s, UEC_RESP_OKAY);
            for (int k = 0; k < 3; k++) rd(map[k+1], {16'h0, m[k]}, UEC_RESP_OKAY);
            chk(rx_maxp, {m[2], m[1], m[0]});
        end
        wr(10'h3FF, 32'hFF, 4'hF, UEC_RESP_SLVERR);
        rd(10'h3FF, 32'h0, UEC_RESP_SLVERR);
        // Control byte table; enable cleared before its variant
        for (int i = 0; i < 5; i++) begin
            v = rnd();
            shared <= v[0];
            space <= v[1];
            wr(UEC_IDX_TX_CTRL_HIGH, {24'h0, seq[i]}, 4'hF, UEC_RESP_OKAY);
            tg ^= seq[i][3];
            rd(UEC_IDX_TX_CTRL_HIGH, {24'h0, seq[i] & 8'hF4}, UEC_RESP_OKAY);
            chk(tx_cfg, {1'b0, seq[i][6], v[0] ? seq[i][5] : 1'b1, seq[i][2], tg});
            chk(tx_dma_req, seq[i][4] & v[1]);
        end
        // No automatic ready one byte short of a full packet; mode 0 DMA asks
        space <= 1'b1;
        fill <= 12'h03F;
        wr(UEC_IDX_TX_MAXP, 32'h40, 4'hF, UEC_RESP_OKAY);
        rd(UEC_IDX_TX_MAXP, 32'h40, UEC_RESP_OKAY);
        wr(UEC_IDX_TX_CTRL_HIGH, 32'h90, 4'hF, UEC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({tx_cfg.tx_packet_ready, tx_dma_req}, 2'h1);
        // Clock enable low freezes the automatic set and drops the readies
        ce <= 1'b0;
        fill <= 12'h040;
        repeat (3) @(posedge aclk);
        chk({tx_cfg.tx_packet_ready, s_axil_awready, s_axil_arready}, 3'h0);
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({tx_cfg.tx_packet_ready, tx_dma_req}, 2'h2);
        // Mode 1 asks with a packet pending; enable later cleared before its variant
        wr(UEC_IDX_TX_CTRL_HIGH, 32'h94, 4'hF, UEC_RESP_OKAY);
        chk({tx_cfg.tx_packet_ready, tx_dma_req}, 2'h3);
        fill <= 12'h000;
        wr(UEC_IDX_TX_CTRL_HIGH, 32'h0C, 4'hF, UEC_RESP_OKAY);
        tg ^= 1'b1;
        rd(UEC_IDX_TX_STATUS, {29'h0, shared, tg, 1'b0}, UEC_RESP_OKAY);
        // Manual ready, drained by the far side after a lag
        lag <= 4'h3;
        wr(UEC_IDX_TX_STATUS, 32'h1, 4'hF, UEC_RESP_OKAY);
        chk(tx_cfg.tx_packet_ready, 1'b1);
        for (n = 0; n < 40 && tx_cfg.tx_packet_ready !== 1'b0; n++) @(posedge aclk);
        tmo();
        tg ^= 1'b1;
        rd(UEC_IDX_TX_STATUS, {29'h0, shared, tg, 1'b0}, UEC_RESP_OKAY);
        chk(flips, 2);
        rst();
        close_out();
    end
endmodule // testbench
